/* File: rtl/lsu_agen.sv */
// Load/store address generation, writeback and load data sizing.
// Assumes decode supplies operand values; memory answers in the request cycle.
// Operation
// - Pc-relative op writes pc plus/minus immediate into destination.
// - Pc-relative displacement spans -4095 to +4095.
// - No condition flags are touched by any operation here.
// - Unsigned byte/half loads zero-extend; words pass whole.
// - Signed byte/half sign-extend and are refused for stores.
// - Offset mode uses base plus/minus imm, base unchanged.
// - Pre-indexed uses base plus/minus imm and writes it back.
// - Post-indexed uses base, then writes base plus/minus imm back.
// - Single offsets -255..4095 offset mode, -255..255 indexed.
// - Pair offsets are multiples of 4 within -1020..1020.
// - Word load into pc as first register branches to value with bit 0 cleared; a pair's second register does not.
// - Register offset is base plus index shifted left 0..3.
// - Register offset allows byte, half, word, signed byte and signed half, no pair.
// - Loads write one or two registers plus any written-back base, stores one or two words.
`default_nettype none
module lsu_agen
   import lsu_agen_pkg::*;
(
   input  wire logic              SYS_CLK_I,
   input  wire logic              RESET_N_I,
   input  wire logic              REQ_VALID_I,
   input  wire logic [2:0]        OP_KIND_I,
   input  wire logic [1:0]        ADDR_MODE_I,
   input  wire logic [2:0]        SIZE_I,
   input  wire logic              IMM_SUB_I,
   input  wire logic [IMM_W-1:0]  IMM_I,
   input  wire logic [SHIFT_W-1:0] LEFT_SHIFT_AMOUNT_I,
   input  wire logic [DATA_W-1:0] PC_VAL_I,
   input  wire logic [DATA_W-1:0] BASE_VAL_I,
   input  wire logic [DATA_W-1:0] INDEX_VAL_I,
   input  wire logic [DATA_W-1:0] STORE_DATA_I,
   input  wire logic [DATA_W-1:0] STORE_DATA2_I,
   input  wire logic [REG_W-1:0]  TRANSFER_REG_I,
   input  wire logic [REG_W-1:0]  SECOND_TRANSFER_REG_I,
   input  wire logic [REG_W-1:0]  BASE_REG_I,
   input  wire logic [DATA_W-1:0] MEM_RDATA_I,
   output logic                   BUSY_O,
   output logic                   ILLEGAL_O,
   output logic                   MEM_REQ_O,
   output logic                   MEM_WE_O,
   output logic [DATA_W-1:0]      MEM_ADDR_O,
   output logic [DATA_W-1:0]      MEM_WDATA_O,
   output logic [2:0]             MEM_SIZE_O,
   output logic                   RF_WE_O,
   output logic [REG_W-1:0]       RF_WADDR_O,
   output logic [DATA_W-1:0]      RF_WDATA_O,
   output logic                   BRANCH_O,
   output logic [DATA_W-1:0]      BRANCH_TARGET_O
);
   ////////////////////////////////////////////////////////////////////
   function automatic logic off_in_range(input logic pair, input logic [1:0] mode,
                                         input logic sub, input logic [IMM_W-1:0] imm);
      logic ok;
      ok = 1'b1;
      if (pair) begin
         ok = (imm[1:0] == 2'h0) && (imm <= IMM_W'(PAIR_OFF_MAX));
      end else if (mode == MODE_OFFSET && !sub) begin
         ok = imm <= IMM_W'(SINGLE_OFF_MAX);
      end else begin
         ok = imm <= IMM_W'(INDEX_OFF_MAX);
      end
      return ok;
   endfunction

   lsu_agen_if sz_if ();
   lsu_data_sizer u_sizer (.bus(sz_if.sizer));

   ////////////////////////////////////////////////////////////////////
   state_t            state_reg, state_next;
   logic              busy_reg, busy_next;
   logic              illegal_reg, illegal_next;
   logic              mreq_reg, mreq_next;
   logic              mwe_reg, mwe_next;
   logic [DATA_W-1:0] maddr_reg, maddr_next;
   logic [DATA_W-1:0] mwdata_reg, mwdata_next;
   logic [2:0]        msize_reg, msize_next;
   logic              rfwe_reg, rfwe_next;
   logic [REG_W-1:0]  rfwaddr_reg, rfwaddr_next;
   logic [DATA_W-1:0] rfwdata_reg, rfwdata_next;
   logic              br_reg, br_next;
   logic [DATA_W-1:0] brt_reg, brt_next;
   logic              load_reg, load_next;
   logic              pair_reg, pair_next;
   logic [REG_W-1:0]  rt_reg, rt_next;
   logic [REG_W-1:0]  rt2_reg, rt2_next;
   logic [DATA_W-1:0] wb_val_reg, wb_val_next;
   logic [REG_W-1:0]  wb_reg_reg, wb_reg_next;
   logic              wb_pend_reg, wb_pend_next;
   logic [DATA_W-1:0] st2_reg, st2_next;

   logic [DATA_W-1:0] offset_v;
   logic [DATA_W-1:0] sum_v;
   logic [DATA_W-1:0] ea_v;
   logic              is_load, is_pair, legal_v;

   assign sz_if.raw_data = MEM_RDATA_I;
   assign sz_if.size_sel = msize_reg;
   assign sz_if.byte_off = maddr_reg[1:0];

   always_comb begin
      is_load  = (OP_KIND_I == OP_LOAD) || (OP_KIND_I == OP_LOAD_PR);
      is_pair  = (OP_KIND_I == OP_LOAD_PR) || (OP_KIND_I == OP_STORE_PR);
      if (ADDR_MODE_I == MODE_REG) begin
         offset_v = INDEX_VAL_I << LEFT_SHIFT_AMOUNT_I;
      end else begin
         offset_v = {{(DATA_W-IMM_W){1'b0}}, IMM_I};
      end
      sum_v = IMM_SUB_I && ADDR_MODE_I != MODE_REG ? BASE_VAL_I - offset_v : BASE_VAL_I + offset_v;
      ea_v  = (ADDR_MODE_I == MODE_POST) ? BASE_VAL_I : sum_v;
      legal_v = 1'b1;
      if (OP_KIND_I == OP_PC_REL) begin
         legal_v = IMM_I <= IMM_W'(PC_REL_MAX);
      end else if (ADDR_MODE_I == MODE_REG) begin
         legal_v = !is_pair && SIZE_I <= 3'(SZ_SHALF);
      end else begin
         legal_v = off_in_range(is_pair, ADDR_MODE_I, IMM_SUB_I, IMM_I);
      end
      if (!is_load && (SIZE_I == SZ_SBYTE || SIZE_I == SZ_SHALF)) begin
         legal_v = legal_v && (OP_KIND_I == OP_PC_REL);
      end
      if (is_pair && SIZE_I != SZ_WORD) begin
         legal_v = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pair and pc-relative handling; flags are never an output here.
   always_comb begin
      state_next   = state_reg;
      busy_next    = busy_reg;
      illegal_next = 1'b0;
      mreq_next    = 1'b0;
      mwe_next     = 1'b0;
      maddr_next   = maddr_reg;
      mwdata_next  = mwdata_reg;
      msize_next   = msize_reg;
      rfwe_next    = 1'b0;
      rfwaddr_next = rfwaddr_reg;
      rfwdata_next = rfwdata_reg;
      br_next      = 1'b0;
      brt_next     = brt_reg;
      load_next    = load_reg;
      pair_next    = pair_reg;
      rt_next      = rt_reg;
      rt2_next     = rt2_reg;
      wb_val_next  = wb_val_reg;
      wb_reg_next  = wb_reg_reg;
      wb_pend_next = wb_pend_reg;
      st2_next     = st2_reg;
      case (state_reg)
         ST_IDLE: begin
            busy_next = 1'b0;
            if (REQ_VALID_I && !legal_v) begin
               illegal_next = 1'b1;
            end else if (REQ_VALID_I && OP_KIND_I == OP_PC_REL) begin
               rfwe_next    = 1'b1;
               rfwaddr_next = TRANSFER_REG_I;
               rfwdata_next = IMM_SUB_I ? PC_VAL_I - offset_v : PC_VAL_I + offset_v;
            end else if (REQ_VALID_I) begin
               busy_next    = 1'b1;
               mreq_next    = 1'b1;
               mwe_next     = !is_load;
               maddr_next   = ea_v;
               mwdata_next  = STORE_DATA_I;
               msize_next   = SIZE_I;
               load_next    = is_load;
               pair_next    = is_pair;
               rt_next      = TRANSFER_REG_I;
               rt2_next     = SECOND_TRANSFER_REG_I;
               st2_next     = STORE_DATA2_I;
               wb_val_next  = sum_v;
               wb_reg_next  = BASE_REG_I;
               wb_pend_next = ADDR_MODE_I == MODE_PRE || ADDR_MODE_I == MODE_POST;
               state_next   = ST_FIRST;
            end
         end
         ST_FIRST: begin
            if (load_reg) begin
               rfwe_next    = sz_if.size_ok;
               rfwaddr_next = rt_reg;
               rfwdata_next = sz_if.ext_data;
               if (rt_reg == PC_IDX && msize_reg == SZ_WORD) begin
                  rfwe_next = 1'b0;
                  br_next   = 1'b1;
                  brt_next  = {sz_if.ext_data[DATA_W-1:1], 1'b0};
               end
            end
            if (pair_reg) begin
               mreq_next   = 1'b1;
               mwe_next    = !load_reg;
               maddr_next  = maddr_reg + DATA_W'(PAIR_STEP);
               mwdata_next = st2_reg;
               state_next  = ST_SECOND;
            end else begin
               state_next = ST_IDLE;
               if (!load_reg && wb_pend_reg) begin
                  rfwe_next    = 1'b1;
                  rfwaddr_next = wb_reg_reg;
                  rfwdata_next = wb_val_reg;
                  wb_pend_next = 1'b0;
               end
            end
         end
         ST_SECOND: begin
            if (load_reg) begin
               rfwe_next    = 1'b1;
               rfwaddr_next = rt2_reg;
               rfwdata_next = sz_if.ext_data;
            end else if (wb_pend_reg) begin
               rfwe_next    = 1'b1;
               rfwaddr_next = wb_reg_reg;
               rfwdata_next = wb_val_reg;
               wb_pend_next = 1'b0;
            end
            state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
      // Loads write base one cycle after data so the port stays single
      if (state_reg == ST_IDLE && state_next == ST_IDLE && wb_pend_reg && !REQ_VALID_I) begin
         rfwe_next    = 1'b1;
         rfwaddr_next = wb_reg_reg;
         rfwdata_next = wb_val_reg;
         wb_pend_next = 1'b0;
      end
      if (state_reg == ST_IDLE && state_next == ST_IDLE && wb_pend_reg) begin
         busy_next = !(!REQ_VALID_I);
      end
      if (wb_pend_reg && load_reg && state_next == ST_IDLE && state_reg != ST_IDLE) begin
         busy_next = 1'b1;
      end
      if (state_next != ST_IDLE) begin
         busy_next = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         state_reg   <= ST_IDLE;
         busy_reg    <= 1'b0;
         illegal_reg <= 1'b0;
         mreq_reg    <= 1'b0;
         mwe_reg     <= 1'b0;
         maddr_reg   <= ZERO_WORD;
         mwdata_reg  <= ZERO_WORD;
         msize_reg   <= SZ_WORD;
         rfwe_reg    <= 1'b0;
         rfwaddr_reg <= 4'h0;
         rfwdata_reg <= ZERO_WORD;
         br_reg      <= 1'b0;
         brt_reg     <= ZERO_WORD;
         load_reg    <= 1'b0;
         pair_reg    <= 1'b0;
         rt_reg      <= 4'h0;
         rt2_reg     <= 4'h0;
         wb_val_reg  <= ZERO_WORD;
         wb_reg_reg  <= 4'h0;
         wb_pend_reg <= 1'b0;
         st2_reg     <= ZERO_WORD;
      end else begin
         state_reg   <= state_next;
         busy_reg    <= busy_next;
         illegal_reg <= illegal_next;
         mreq_reg    <= mreq_next;
         mwe_reg     <= mwe_next;
         maddr_reg   <= maddr_next;
         mwdata_reg  <= mwdata_next;
         msize_reg   <= msize_next;
         rfwe_reg    <= rfwe_next;
         rfwaddr_reg <= rfwaddr_next;
         rfwdata_reg <= rfwdata_next;
         br_reg      <= br_next;
         brt_reg     <= brt_next;
         load_reg    <= load_next;
         pair_reg    <= pair_next;
         rt_reg      <= rt_next;
         rt2_reg     <= rt2_next;
         wb_val_reg  <= wb_val_next;
         wb_reg_reg  <= wb_reg_next;
         wb_pend_reg <= wb_pend_next;
         st2_reg     <= st2_next;
      end
   end

   assign BUSY_O          = busy_reg;
   assign ILLEGAL_O       = illegal_reg;
   assign MEM_REQ_O       = mreq_reg;
   assign MEM_WE_O        = mwe_reg;
   assign MEM_ADDR_O      = maddr_reg;
   assign MEM_WDATA_O     = mwdata_reg;
   assign MEM_SIZE_O      = msize_reg;
   assign RF_WE_O         = rfwe_reg;
   assign RF_WADDR_O      = rfwaddr_reg;
   assign RF_WDATA_O      = rfwdata_reg;
   assign BRANCH_O        = br_reg;
   assign BRANCH_TARGET_O = brt_reg;
endmodule // lsu_agen
`default_nettype wire

/* File: rtl/lsu_agen_if.sv */
// Memory request/response bundle between sequencer and data sizer.
// Assumes both ends on the core clock.
`default_nettype none
interface lsu_agen_if;
   import lsu_agen_pkg::*;
   logic [DATA_W-1:0] raw_data;
   logic [2:0]        size_sel;
   logic [1:0]        byte_off;
   logic [DATA_W-1:0] ext_data;
   logic              size_ok;
   modport seq (output raw_data, output size_sel, output byte_off, input ext_data, input size_ok);
   modport sizer (input raw_data, input size_sel, input byte_off, output ext_data, output size_ok);
endinterface
`default_nettype wire

/* File: rtl/lsu_agen_pkg.sv */
// Constants and types for the load/store address generator.
// Assumes a single core clock domain; all users import the whole package.
`default_nettype none
package lsu_agen_pkg;
   localparam int DATA_W        = 32;
   localparam int REG_W         = 4;
   localparam int IMM_W         = 13;
   localparam int SHIFT_W       = 2;
   localparam int PAIR_STEP     = 4;
   localparam int PC_REL_MAX    = 4095;
   localparam int SINGLE_OFF_MAX = 4095;
   localparam int INDEX_OFF_MAX = 255;
   localparam int PAIR_OFF_MAX  = 1020;
   localparam logic [REG_W-1:0] SP_IDX = 4'hD;
   localparam logic [REG_W-1:0] PC_IDX = 4'hF;
   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

   typedef enum logic [2:0] {
      OP_PC_REL   = 3'h0,
      OP_LOAD     = 3'h1,
      OP_STORE    = 3'h2,
      OP_LOAD_PR  = 3'h3,
      OP_STORE_PR = 3'h4
   } op_kind_t;

   typedef enum logic [1:0] {
      MODE_OFFSET = 2'h0,
      MODE_PRE    = 2'h1,
      MODE_POST   = 2'h2,
      MODE_REG    = 2'h3
   } addr_mode_t;

   typedef enum logic [2:0] {
      SZ_BYTE   = 3'h0,
      SZ_HALF   = 3'h1,
      SZ_WORD   = 3'h2,
      SZ_SBYTE  = 3'h3,
      SZ_SHALF  = 3'h4
   } size_t_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FIRST = 2'b01,
      ST_SECOND = 2'b11
   } state_t;
endpackage
`default_nettype wire

/* File: rtl/lsu_data_sizer.sv */
// Extends fetched byte/halfword/word data to a full word.
// Assumes combinational use inside the core clock domain.
`default_nettype none
module lsu_data_sizer
   import lsu_agen_pkg::*;
(
   lsu_agen_if.sizer bus
);
   logic [7:0]  byte_v;
   logic [15:0] half_v;

   always_comb begin
      byte_v = bus.raw_data[8*bus.byte_off +: 8];
      half_v = bus.raw_data[16*bus.byte_off[1] +: 16];
      bus.size_ok = 1'b1;
      case (bus.size_sel)
         SZ_BYTE:  bus.ext_data = {24'h000000, byte_v};
         SZ_HALF:  bus.ext_data = {16'h0000, half_v};
         SZ_SBYTE: bus.ext_data = {{24{byte_v[7]}}, byte_v};
         SZ_SHALF: bus.ext_data = {{16{half_v[15]}}, half_v};
         SZ_WORD:  bus.ext_data = bus.raw_data;
         default: begin
            bus.ext_data = bus.raw_data;
            bus.size_ok  = 1'b0;
         end
      endcase
   end
endmodule // lsu_data_sizer
`default_nettype wire

/* File: testbench/load_store_address_gen_tb.sv */
// Self-checking bench for the load/store address generator.
// Assumes the memory model answers reads in the request cycle.
`default_nettype none
module load_store_address_gen_tb
   import lsu_agen_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {op_kind_t op; addr_mode_t md; size_t_t sz; logic sb; logic [12:0] imm; logic [1:0] sh; logic ill;} row_t;
   localparam logic [31:0] RWORD = 32'h8F7E_6D5C;
   localparam logic [31:0] PC_V = 32'h0000_1000;
   localparam logic [31:0] BASE_V = 32'h2000_0100;
   localparam logic [31:0] IDX_V = 32'h0000_0043;
   localparam logic [31:0] SD_V = 32'h1122_3344;
   localparam logic [31:0] SD2_V = 32'h5566_7788;
   logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, sb = 1'b0, ill, busy, mreq, mwe, rfwe, br;
   logic [2:0] op = 3'h0, sz = 3'h2, msize;
   logic [1:0] md = 2'h0, sh = 2'h0;
   logic [12:0] imm = 13'h0000;
   logic [3:0] rt = 4'h1, rfwa;
   logic [31:0] rdata, maddr, mwd, rfwd, brt, brt_q;
   logic [31:0] ma[$], md_q[$], rd[$];
   logic mw[$];
   logic [3:0] ra[$];
   int error_cnt = 0, tests_run = 0, ill_n, br_n;
   row_t rows[20] = '{
      '{OP_PC_REL, MODE_OFFSET, SZ_WORD, 1'b0, 13'h0FFF, 2'h0, 1'b0}, '{OP_PC_REL, MODE_OFFSET, SZ_WORD, 1'b1, 13'h0FFF, 2'h0, 1'b0},
      '{OP_LOAD, MODE_OFFSET, SZ_BYTE, 1'b0, 13'h0FFF, 2'h0, 1'b0}, '{OP_LOAD, MODE_OFFSET, SZ_SBYTE, 1'b1, 13'h00FF, 2'h0, 1'b0},
      '{OP_LOAD, MODE_PRE, SZ_HALF, 1'b0, 13'h0002, 2'h0, 1'b0}, '{OP_LOAD, MODE_POST, SZ_SHALF, 1'b1, 13'h00FE, 2'h0, 1'b0},
      '{OP_LOAD, MODE_REG, SZ_WORD, 1'b0, 13'h0000, 2'h3, 1'b0}, '{OP_LOAD, MODE_REG, SZ_SBYTE, 1'b0, 13'h0000, 2'h1, 1'b0},
      '{OP_STORE, MODE_OFFSET, SZ_WORD, 1'b1, 13'h0004, 2'h0, 1'b0}, '{OP_STORE, MODE_PRE, SZ_WORD, 1'b0, 13'h00FF, 2'h0, 1'b0},
      '{OP_STORE, MODE_POST, SZ_BYTE, 1'b1, 13'h00FF, 2'h0, 1'b0}, '{OP_STORE, MODE_REG, SZ_HALF, 1'b0, 13'h0000, 2'h2, 1'b0},
      '{OP_LOAD_PR, MODE_OFFSET, SZ_WORD, 1'b0, 13'h03FC, 2'h0, 1'b0}, '{OP_LOAD_PR, MODE_PRE, SZ_WORD, 1'b1, 13'h03FC, 2'h0, 1'b0},
      '{OP_STORE_PR, MODE_POST, SZ_WORD, 1'b0, 13'h0008, 2'h0, 1'b0}, '{OP_STORE, MODE_OFFSET, SZ_SBYTE, 1'b0, 13'h0000, 2'h0, 1'b1},
      '{OP_LOAD, MODE_PRE, SZ_WORD, 1'b0, 13'h0100, 2'h0, 1'b1}, '{OP_LOAD, MODE_OFFSET, SZ_WORD, 1'b1, 13'h0100, 2'h0, 1'b1},
      '{OP_LOAD_PR, MODE_OFFSET, SZ_WORD, 1'b0, 13'h0006, 2'h0, 1'b1}, '{OP_LOAD_PR, MODE_REG, SZ_WORD, 1'b0, 13'h0000, 2'h0, 1'b1}};
   // Register numbers kept distinct and off sp/pc unless a test says otherwise
   lsu_agen i_lsu_agen (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .REQ_VALID_I(valid), .OP_KIND_I(op), .ADDR_MODE_I(md),
      .SIZE_I(sz), .IMM_SUB_I(sb), .IMM_I(imm), .LEFT_SHIFT_AMOUNT_I(sh), .PC_VAL_I(PC_V), .BASE_VAL_I(BASE_V),
      .INDEX_VAL_I(IDX_V), .STORE_DATA_I(SD_V), .STORE_DATA2_I(SD2_V), .TRANSFER_REG_I(rt), .SECOND_TRANSFER_REG_I(4'h2),
      .BASE_REG_I(4'h5), .MEM_RDATA_I(rdata), .BUSY_O(busy), .ILLEGAL_O(ill), .MEM_REQ_O(mreq), .MEM_WE_O(mwe),
      .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwd), .MEM_SIZE_O(msize), .RF_WE_O(rfwe), .RF_WADDR_O(rfwa),
      .RF_WDATA_O(rfwd), .BRANCH_O(br), .BRANCH_TARGET_O(brt));
   lsu_mem_model #(.RWORD(RWORD)) i_lsu_mem_model (.clk_i(clk), .req_i(mreq), .we_i(mwe), .addr_i(maddr), .rdata_o(rdata));
   initial forever #4 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   // Outputs are sampled mid-cycle so one-cycle pulses are seen settled
   always @(negedge clk) begin
      if (mreq === 1'b1) begin ma.push_back(maddr); md_q.push_back(mwd); mw.push_back(mwe); end
      if (rfwe === 1'b1) begin ra.push_back(rfwa); rd.push_back(rfwd); end
      if (ill === 1'b1) ill_n++;
      if (br === 1'b1) begin br_n++; brt_q = brt; end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin error_cnt++; $display("Error at %0t: got %h expected %h", $time, got, exp); end
   endtask
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic run(input row_t r);
      ma.delete(); md_q.delete(); mw.delete(); ra.delete(); rd.delete(); ill_n = 0; br_n = 0;
      @(negedge clk);
      op = r.op; md = r.md; sz = r.sz; sb = r.sb; imm = r.imm; sh = r.sh; valid = 1'b1;
      @(negedge clk);
      valid = 1'b0;
      for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk);
      repeat (3) @(negedge clk);
   endtask
   function automatic logic [31:0] ext(input logic [2:0] s, input logic [31:0] w, input logic [1:0] a);
      logic [7:0] b;
      logic [15:0] h;
      b = w[8*a +: 8];
      h = w[16*a[1] +: 16];
      case (s)
         3'h0: return {24'h0, b};
         3'h1: return {16'h0, h};
         3'h3: return {{24{b[7]}}, b};
         3'h4: return {{16{h[15]}}, h};
         default: return w;
      endcase
   endfunction
   task automatic check_row(input row_t r);
      logic [31:0] ea, acc;
      logic wb, ld, pr;
      ea = r.md == MODE_REG ? BASE_V + (IDX_V << r.sh) : (r.sb ? BASE_V - r.imm : BASE_V + r.imm);
      acc = r.md == MODE_POST ? BASE_V : ea;
      wb = r.md == MODE_PRE || r.md == MODE_POST;
      ld = r.op == OP_LOAD || r.op == OP_LOAD_PR;
      pr = r.op == OP_LOAD_PR || r.op == OP_STORE_PR;
      if (r.ill) begin
         chk(ill_n, 1);
         chk(ma.size() + rd.size(), 0);
      end else if (r.op == OP_PC_REL) begin
         chk(rd.size(), 1);
         chk(rd[0], r.sb ? PC_V - r.imm : PC_V + r.imm);
      end else begin
         chk(ma.size(), pr ? 2 : 1);
         chk(ma[0], acc);
         chk(mw[0], !ld);
         if (pr) chk(ma[1], acc + 4);
         if (ld) chk(rd[0], ext(r.sz, RWORD ^ acc, acc[1:0]));
         if (ld && pr) chk(rd[1], RWORD ^ (acc + 4));
         if (ld) chk(ra[0], 4'h1);
         if (ld && pr) chk(ra[1], 4'h2);
         if (!ld && r.sz == SZ_WORD) chk(md_q[0], SD_V);
         if (!ld && pr) chk(md_q[1], SD2_V);
         chk(rd.size(), (ld ? (pr ? 2 : 1) : 0) + wb);
         if (wb) chk(ra[rd.size() - 1], 4'h5);
         if (wb) chk(rd[rd.size() - 1], ea);
      end
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      stop_test();
   end
   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      foreach (rows[i]) begin
         run(rows[i]);
         check_row(rows[i]);
      end
      rt = PC_IDX;
      run('{OP_LOAD, MODE_OFFSET, SZ_WORD, 1'b0, 13'h0004, 2'h0, 1'b0});
      chk(br_n, 1);
      chk(brt_q, (RWORD ^ (BASE_V + 4)) & 32'hFFFF_FFFE);
      rt = 4'h1;
      run('{OP_PC_REL, MODE_OFFSET, SZ_WORD, 1'b0, 13'h0001, 2'h0, 1'b0});
      // Two pc-relative requests on consecutive edges, valid held high
      valid = 1'b1;
      @(negedge clk);
      imm = 13'h0002;
      @(negedge clk);
      valid = 1'b0;
      repeat (3) @(negedge clk);
      chk(rd.size(), 3);
      chk(rd[1], PC_V + 1);
      chk(rd[2], PC_V + 2);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      chk({busy, mreq, rfwe, br, ill, msize}, {5'h00, 3'h2});
      rst_n = 1'b1;
      stop_test();
   end
endmodule // load_store_address_gen_tb
`default_nettype wire

/* File: testbench/lsu_agen_checker.sv */
// Concurrent checks on the load/store address generator top ports.
// Assumes one core clock and a synchronous active-low reset.
`default_nettype none
module lsu_agen_checker
   import lsu_agen_pkg::*;
(
   input wire logic               SYS_CLK_I,
   input wire logic               RESET_N_I,
   input wire logic               REQ_VALID_I,
   input wire logic [2:0]         OP_KIND_I,
   input wire logic [1:0]         ADDR_MODE_I,
   input wire logic [2:0]         SIZE_I,
   input wire logic               IMM_SUB_I,
   input wire logic [IMM_W-1:0]   IMM_I,
   input wire logic [SHIFT_W-1:0] LEFT_SHIFT_AMOUNT_I,
   input wire logic [DATA_W-1:0]  PC_VAL_I,
   input wire logic [DATA_W-1:0]  BASE_VAL_I,
   input wire logic [DATA_W-1:0]  INDEX_VAL_I,
   input wire logic [DATA_W-1:0]  MEM_RDATA_I,
   input wire logic               BUSY_O,
   input wire logic               ILLEGAL_O,
   input wire logic               MEM_REQ_O,
   input wire logic [DATA_W-1:0]  MEM_ADDR_O,
   input wire logic               RF_WE_O,
   input wire logic [DATA_W-1:0]  RF_WDATA_O,
   input wire logic               BRANCH_O,
   input wire logic [DATA_W-1:0]  BRANCH_TARGET_O
);
   timeunit 1ns;
   timeprecision 1ps;
   logic              take;
   logic              single;
   logic              pair;
   logic              s_ok;
   logic [DATA_W-1:0] ea;
   logic [DATA_W-1:0] rea;
   logic [DATA_W-1:0] pcsum;
   assign take = REQ_VALID_I && !BUSY_O;
   assign single = OP_KIND_I == OP_LOAD || OP_KIND_I == OP_STORE;
   assign pair = OP_KIND_I == OP_LOAD_PR || OP_KIND_I == OP_STORE_PR;
   assign ea = IMM_SUB_I ? BASE_VAL_I - {19'h0, IMM_I} : BASE_VAL_I + {19'h0, IMM_I};
   assign rea = BASE_VAL_I + (INDEX_VAL_I << LEFT_SHIFT_AMOUNT_I);
   assign pcsum = IMM_SUB_I ? PC_VAL_I - {19'h0, IMM_I} : PC_VAL_I + {19'h0, IMM_I};
   // Legal single transfers only: no signed store, no range refusal
   assign s_ok = single && SIZE_I <= 3'h4 && (SIZE_I <= SZ_WORD || OP_KIND_I == OP_LOAD) && IMM_I <= 13'h00FF;
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   ////////////////////////////////////////////////////////////////////////////
   a_pc_rel_sum: assert property (take && OP_KIND_I == OP_PC_REL && IMM_I <= 13'h0FFF |=>
      RF_WE_O && RF_WDATA_O == $past(pcsum)) else $error("pc-relative sum wrong");
   a_offset_addr: assert property (take && s_ok && ADDR_MODE_I == MODE_OFFSET |=>
      MEM_REQ_O && MEM_ADDR_O == $past(ea)) else $error("offset address wrong");
   a_pre_addr: assert property (take && s_ok && ADDR_MODE_I == MODE_PRE |=>
      MEM_REQ_O && MEM_ADDR_O == $past(ea)) else $error("pre-index address wrong");
   a_post_addr: assert property (take && s_ok && ADDR_MODE_I == MODE_POST |=>
      MEM_REQ_O && MEM_ADDR_O == $past(BASE_VAL_I)) else $error("post-index address wrong");
   a_reg_addr: assert property (take && s_ok && ADDR_MODE_I == MODE_REG |=>
      MEM_REQ_O && MEM_ADDR_O == $past(rea)) else $error("register offset address wrong");
   a_pair_step: assert property (take && pair && SIZE_I == SZ_WORD && ADDR_MODE_I != MODE_REG &&
      IMM_I[1:0] == 2'h0 && IMM_I <= 13'h03FC |=> MEM_REQ_O ##1 MEM_REQ_O && MEM_ADDR_O == $past(MEM_ADDR_O) + 32'h4)
      else $error("pair second address wrong");
   a_range_refuse: assert property (take && single && (ADDR_MODE_I == MODE_PRE || ADDR_MODE_I == MODE_POST) &&
      IMM_I > 13'h00FF |=> ILLEGAL_O && !MEM_REQ_O) else $error("indexed range not refused");
   a_signed_store: assert property (take && OP_KIND_I == OP_STORE && (SIZE_I == SZ_SBYTE || SIZE_I == SZ_SHALF)
      |=> ILLEGAL_O) else $error("signed store not refused");
   a_pair_align: assert property (take && pair && IMM_I[1:0] != 2'h0 |=> ILLEGAL_O ##1 !MEM_REQ_O && !RF_WE_O)
      else $error("misaligned pair offset not refused");
   a_branch_clear: assert property (BRANCH_O |-> BRANCH_TARGET_O == ($past(MEM_RDATA_I) & 32'hFFFF_FFFE))
      else $error("branch target wrong");
   a_quiet_refuse: assert property (ILLEGAL_O |-> !MEM_REQ_O && !RF_WE_O && !BRANCH_O)
      else $error("refused request caused activity");
   c_pair: cover property (take && pair);
   c_branch: cover property (BRANCH_O);
   c_refuse: cover property (ILLEGAL_O);
endmodule // lsu_agen_checker
bind lsu_agen lsu_agen_checker i_lsu_agen_checker (.SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I),
   .REQ_VALID_I(REQ_VALID_I), .OP_KIND_I(OP_KIND_I), .ADDR_MODE_I(ADDR_MODE_I), .SIZE_I(SIZE_I),
   .IMM_SUB_I(IMM_SUB_I), .IMM_I(IMM_I), .LEFT_SHIFT_AMOUNT_I(LEFT_SHIFT_AMOUNT_I), .PC_VAL_I(PC_VAL_I),
   .BASE_VAL_I(BASE_VAL_I), .INDEX_VAL_I(INDEX_VAL_I), .MEM_RDATA_I(MEM_RDATA_I), .BUSY_O(BUSY_O),
   .ILLEGAL_O(ILLEGAL_O), .MEM_REQ_O(MEM_REQ_O), .MEM_ADDR_O(MEM_ADDR_O), .RF_WE_O(RF_WE_O),
   .RF_WDATA_O(RF_WDATA_O), .BRANCH_O(BRANCH_O), .BRANCH_TARGET_O(BRANCH_TARGET_O));
`default_nettype wire

/* File: testbench/lsu_mem_model.sv */
// Data memory stand-in: answers reads in the request cycle.
// Assumes requests come from the registered outputs of the generator.
`default_nettype none
module lsu_mem_model #(
   parameter logic [31:0] RWORD = 32'h8F7E_6D5C
) (
   input  wire logic        clk_i,
   input  wire logic        req_i,
   input  wire logic        we_i,
   input  wire logic [31:0] addr_i,
   output var  logic [31:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] last_reg = 32'h0000_0000;
   // Idle bus shows the inverse of the last word, never a stale match
   always_comb rdata_o = (req_i && !we_i) ? (RWORD ^ addr_i) : ~last_reg;
   always_ff @(posedge clk_i) last_reg <= rdata_o;
endmodule // lsu_mem_model
`default_nettype wire
